//--- common/wsbe_pkg.sv
// Constants for the weigh status byte encoder: frame characters, bit positions, field widths.
// Assumes one 25 MHz system clock; no bus, all configuration arrives on plain ports.
package wsbe_pkg;
   localparam logic [7:0] CHAR_START   = 8'h02;
   localparam logic [7:0] CHAR_CR      = 8'h0d;
   localparam logic [6:0] CHECK_MASK   = 7'h7f;
   localparam int         WEIGHT_DIGITS = 6;
   localparam int         TARE_DIGITS  = 6;
   localparam logic [3:0] IDX_STATUS_A = 4'h1;
   localparam logic [3:0] IDX_STATUS_B = 4'h2;
   localparam logic [3:0] IDX_STATUS_C = 4'h3;
   localparam logic [3:0] IDX_WEIGHT0  = 4'h4;
   localparam logic [3:0] IDX_TARE0    = 4'ha;
   // Status bit positions.
   localparam int A_BUILD_LO  = 3;
   localparam int A_BUILD_HI  = 4;
   localparam int X_ALWAYS1   = 5;
   localparam int X_BIT6      = 6;
   localparam int B_NET       = 0;
   localparam int B_NEG       = 1;
   localparam int B_RANGE     = 2;
   localparam int B_MOTION    = 3;
   localparam int B_KG        = 4;
   localparam int C_PRINT     = 3;
   localparam int C_BIT4      = 4;

   typedef enum logic [2:0] {
      WSBE_IDLE  = 3'b000,
      WSBE_HEAD  = 3'b001,
      WSBE_BODY  = 3'b010,
      WSBE_CR    = 3'b011,
      WSBE_CHECK = 3'b100
   } wsbe_state_t;
endpackage : wsbe_pkg

//--- logic/wsbe_encoder.sv
// Continuous weight frame builder: start, three status characters, weight, optional tare,
// carriage return and optional check character, one character per accepted handshake.
// Assumes the downstream transmitter raises CHAR_READY when it can take a character and
// that digit inputs are already ASCII.
`timescale 1ns/1ps

module wsbe_encoder (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        FRAME_REQ,
   input  wire logic        LONG_FORMAT,
   input  wire logic        CHECK_EN,
   input  wire logic        SETPOINT_MODE,
   input  wire logic        TWO_SPEED,
   input  wire logic [2:0]  DP_CODE,
   input  wire logic [1:0]  BUILD_CODE,
   input  wire logic        NET,
   input  wire logic        NEGATIVE,
   input  wire logic        OUT_OF_RANGE,
   input  wire logic        MOTION,
   input  wire logic        KG_SEL,
   input  wire logic        POWER_UP,
   input  wire logic [2:0]  UNIT_CODE,
   input  wire logic        PRINT_REQ,
   input  wire logic        EXPAND,
   input  wire logic        HAND_TARE,
   input  wire logic        METRIC,
   input  wire logic [3:0]  SP_FEED,
   input  wire logic [1:0]  SP_FAST,
   input  wire logic        SP1_OUT_TOL,
   input  wire logic        SP2_OUT_TOL,
   input  wire logic [47:0] WEIGHT_ASCII,
   input  wire logic [47:0] TARE_ASCII,
   input  wire logic        CHAR_READY,
   output logic      [7:0]  CHAR_DATA,
   output logic             CHAR_VALID,
   output logic             FRAME_BUSY
);

   typedef struct packed {
      wsbe_pkg::wsbe_state_t state;
      logic [3:0]            idx;
      logic [7:0]            stat_a;
      logic [7:0]            stat_b;
      logic [7:0]            stat_c;
      logic [47:0]           weight;
      logic [47:0]           tare;
      logic                  long_fmt;
      logic                  check_en;
      logic [6:0]            sum;
      logic [7:0]            data;
      logic                  valid;
      logic                  busy;
   } wsbe_regs_t;

   wsbe_regs_t s_reg;
   wsbe_regs_t s_next;

   // Pick ASCII digit n (most significant first) out of a six-digit field.
   function automatic logic [7:0] wsbe_digit(input logic [47:0] f, input logic [3:0] n);
      logic [47:0] sh;
      sh = f << {n, 3'h0};
      return sh[47:40];
   endfunction : wsbe_digit

   logic [7:0] a_char;
   logic [7:0] b_char;
   logic [7:0] c_char;
   logic       sp_a3;
   logic       sp_a4;
   logic       sp_a6;
   logic       sp_c4;
   logic [7:0] nxt_char;
   logic       last_body;

   always_comb begin
      // Feeding reads as zero in the status, hence the inversions.
      sp_a3 = ~SP_FEED[0];
      sp_a4 = ~SP_FEED[1];
      sp_a6 = TWO_SPEED ? ~SP_FAST[0] : ~SP_FEED[2];
      sp_c4 = TWO_SPEED ? ~SP_FAST[1] : ~SP_FEED[3];
      a_char = 8'h00;
      b_char = 8'h00;
      c_char = 8'h00;
      a_char[2:0] = DP_CODE;
      a_char[wsbe_pkg::X_ALWAYS1] = 1'b1;
      b_char[wsbe_pkg::B_NET] = NET;
      b_char[wsbe_pkg::B_NEG] = NEGATIVE;
      b_char[wsbe_pkg::B_RANGE] = OUT_OF_RANGE;
      b_char[wsbe_pkg::B_MOTION] = MOTION;
      b_char[wsbe_pkg::B_KG] = KG_SEL;
      b_char[wsbe_pkg::X_ALWAYS1] = 1'b1;
      c_char[2:0] = UNIT_CODE;
      c_char[wsbe_pkg::C_PRINT] = PRINT_REQ;
      c_char[wsbe_pkg::X_ALWAYS1] = 1'b1;
      if (SETPOINT_MODE) begin
         a_char[wsbe_pkg::A_BUILD_LO] = sp_a3;
         a_char[wsbe_pkg::A_BUILD_HI] = sp_a4;
         a_char[wsbe_pkg::X_BIT6] = sp_a6;
         b_char[wsbe_pkg::X_BIT6] = SP1_OUT_TOL;
         c_char[wsbe_pkg::C_BIT4] = sp_c4;
         c_char[wsbe_pkg::X_BIT6] = SP2_OUT_TOL;
      end else begin
         a_char[wsbe_pkg::A_BUILD_LO] = BUILD_CODE[0];
         a_char[wsbe_pkg::A_BUILD_HI] = BUILD_CODE[1];
         b_char[wsbe_pkg::X_BIT6] = POWER_UP;
         c_char[wsbe_pkg::C_BIT4] = EXPAND;
         c_char[wsbe_pkg::X_BIT6] = HAND_TARE & METRIC;
      end
   end

   always_comb begin
      s_next = s_reg;
      nxt_char = 8'h00;
      last_body = 1'b0;
      unique case (s_reg.idx)
         wsbe_pkg::IDX_STATUS_A: nxt_char = s_reg.stat_a;
         wsbe_pkg::IDX_STATUS_B: nxt_char = s_reg.stat_b;
         wsbe_pkg::IDX_STATUS_C: nxt_char = s_reg.stat_c;
         default: begin
            if (s_reg.idx < wsbe_pkg::IDX_TARE0) begin
               nxt_char = wsbe_digit(s_reg.weight, s_reg.idx - wsbe_pkg::IDX_WEIGHT0);
            end else begin
               nxt_char = wsbe_digit(s_reg.tare, s_reg.idx - wsbe_pkg::IDX_TARE0);
            end
         end
      endcase
      last_body = s_reg.long_fmt
                ? (s_reg.idx == wsbe_pkg::IDX_TARE0 + 4'(wsbe_pkg::TARE_DIGITS - 1))
                : (s_reg.idx == wsbe_pkg::IDX_TARE0 - 4'h1);
      unique case (s_reg.state)
         wsbe_pkg::WSBE_IDLE: begin
            if (FRAME_REQ) begin
               // One snapshot per frame keeps the three status characters coherent.
               s_next.stat_a = a_char;
               s_next.stat_b = b_char;
               s_next.stat_c = c_char;
               s_next.weight = WEIGHT_ASCII;
               s_next.tare = TARE_ASCII;
               s_next.long_fmt = LONG_FORMAT;
               s_next.check_en = CHECK_EN;
               s_next.data = wsbe_pkg::CHAR_START;
               s_next.sum = wsbe_pkg::CHAR_START[6:0];
               s_next.valid = 1'b1;
               s_next.busy = 1'b1;
               s_next.idx = wsbe_pkg::IDX_STATUS_A;
               s_next.state = wsbe_pkg::WSBE_BODY;
            end
         end
         wsbe_pkg::WSBE_BODY: begin
            if (CHAR_READY) begin
               s_next.data = nxt_char;
               s_next.sum = s_reg.sum + nxt_char[6:0];
               s_next.idx = s_reg.idx + 4'h1;
               if (last_body) begin
                  s_next.state = wsbe_pkg::WSBE_CR;
               end
            end
         end
         wsbe_pkg::WSBE_CR: begin
            if (CHAR_READY) begin
               s_next.data = wsbe_pkg::CHAR_CR;
               s_next.sum = s_reg.sum + wsbe_pkg::CHAR_CR[6:0];
               s_next.state = s_reg.check_en ? wsbe_pkg::WSBE_CHECK : wsbe_pkg::WSBE_HEAD;
            end
         end
         wsbe_pkg::WSBE_CHECK: begin
            if (CHAR_READY) begin
               s_next.data = {1'b0, (~s_reg.sum + 7'h01) & wsbe_pkg::CHECK_MASK};
               s_next.state = wsbe_pkg::WSBE_HEAD;
            end
         end
         wsbe_pkg::WSBE_HEAD: begin
            // Waits for the final character to be taken, then frees the framer.
            if (CHAR_READY) begin
               s_next.valid = 1'b0;
               s_next.busy = 1'b0;
               s_next.state = wsbe_pkg::WSBE_IDLE;
            end
         end
         default: s_next.state = wsbe_pkg::WSBE_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign CHAR_DATA = s_reg.data;
   assign CHAR_VALID = s_reg.valid;
   assign FRAME_BUSY = s_reg.busy;

   // Keyed on the frame position, because a digit or check character may also equal 02h.
   sequence start_taken_s;
      s_reg.state == wsbe_pkg::WSBE_BODY && s_reg.idx == wsbe_pkg::IDX_STATUS_A && CHAR_READY;
   endsequence

   start_first_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      $rose(CHAR_VALID) |-> CHAR_DATA == wsbe_pkg::CHAR_START)
      else $error("Frame did not open with start character");
   status_a_fix_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      start_taken_s |=> CHAR_DATA[wsbe_pkg::X_ALWAYS1] == 1'b1 && CHAR_DATA[7] == 1'b0)
      else $error("First status character fixed bits wrong");
   status_b_one_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_reg.state != wsbe_pkg::WSBE_IDLE |-> s_reg.stat_b[wsbe_pkg::X_ALWAYS1])
      else $error("Second status bit 5 not one");
   status_c_one_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_reg.state != wsbe_pkg::WSBE_IDLE |-> s_reg.stat_c[wsbe_pkg::X_ALWAYS1])
      else $error("Third status bit 5 not one");
   snapshot_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_reg.state != wsbe_pkg::WSBE_IDLE && $past(s_reg.state) != wsbe_pkg::WSBE_IDLE
      |-> $stable(s_reg.stat_a) && $stable(s_reg.stat_b))
      else $error("Status snapshot changed inside a frame");
   cr_follows_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_reg.state == wsbe_pkg::WSBE_CR && CHAR_READY |=> CHAR_DATA == wsbe_pkg::CHAR_CR)
      else $error("Carriage return missing");
   check_value_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_reg.state == wsbe_pkg::WSBE_CHECK && CHAR_READY
      |=> CHAR_DATA[6:0] == 7'(~$past(s_reg.sum) + 7'h01))
      else $error("Check character wrong");
   hand_tare_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      FRAME_REQ && !FRAME_BUSY && !SETPOINT_MODE && !METRIC |=> !s_reg.stat_c[wsbe_pkg::X_BIT6])
      else $error("Hand tare shown outside metric");
   valid_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      CHAR_VALID && !CHAR_READY |=> CHAR_VALID && $stable(CHAR_DATA))
      else $error("Character dropped while stalled");
endmodule : wsbe_encoder

//--- tb/wsbe_host_model.sv
// Receiving host model: takes each offered character and hands it on as a one-cycle note.
// Assumes the encoder holds CHAR_DATA and CHAR_VALID until an edge that samples ready high.
`timescale 1ns/1ps
module wsbe_host_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       stall_en,
   input  wire logic [7:0] char_data,
   input  wire logic       char_valid,
   output logic            char_ready,
   output logic            got,
   output logic      [7:0] got_data
);
   logic [1:0] phase_reg = 2'h0;
   // Ready moves on the falling edge, so the encoder never samples it mid-change.
   // A slow host is ready one cycle in four, which keeps every character waiting.
   always @(negedge clk) begin
      phase_reg  <= phase_reg + 2'h1;
      char_ready <= !stall_en || (phase_reg == 2'h3);
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         got      <= 1'b0;
         got_data <= 8'h00;
      end else begin
         got      <= char_valid && char_ready;
         got_data <= char_data;
      end
   end
endmodule : wsbe_host_model

//--- tb/wsbe_encoder_tb.sv
// Self-checking bench for the status frame encoder with a receiving host model.
// Assumes the encoder answers one cycle after a taken request and paces on CHAR_READY.
`timescale 1ns/1ps
module wsbe_encoder_tb;
   logic        clk_sys = 1'b0, rst = 1'b1, frame_req = 1'b0, stall_en = 1'b0;
   logic        long_format = 1'b0, check_en = 1'b0, setpoint_mode = 1'b0, two_speed = 1'b0;
   logic [2:0]  dp_code = 3'h0, unit_code = 3'h0;
   logic [1:0]  build_code = 2'h0, sp_fast = 2'h0;
   logic [3:0]  sp_feed = 4'h0;
   logic        net = 1'b0, negative = 1'b0, out_of_range = 1'b0, motion = 1'b0, kg_sel = 1'b0;
   logic        power_up = 1'b0, print_req = 1'b0, expand = 1'b0, hand_tare = 1'b0;
   logic        metric = 1'b0, sp1_out_tol = 1'b0, sp2_out_tol = 1'b0;
   logic [47:0] weight_ascii = 48'h0, tare_ascii = 48'h0;
   logic        char_ready, char_valid, frame_busy, got;
   logic [7:0]  char_data, got_data;
   logic [31:0] seed = 32'h6cd3;
   logic [6:0]  sum_acc;
   logic [7:0]  exp_q[$];
   int          mismatches = 0, tests_run = 0;

   always #20 clk_sys = ~clk_sys;

   wsbe_encoder i_wsbe_encoder (.CLK_SYS(clk_sys), .RST(rst), .FRAME_REQ(frame_req),
      .LONG_FORMAT(long_format), .CHECK_EN(check_en), .SETPOINT_MODE(setpoint_mode),
      .TWO_SPEED(two_speed), .DP_CODE(dp_code), .BUILD_CODE(build_code), .NET(net),
      .NEGATIVE(negative), .OUT_OF_RANGE(out_of_range), .MOTION(motion), .KG_SEL(kg_sel),
      .POWER_UP(power_up), .UNIT_CODE(unit_code), .PRINT_REQ(print_req), .EXPAND(expand),
      .HAND_TARE(hand_tare), .METRIC(metric), .SP_FEED(sp_feed), .SP_FAST(sp_fast),
      .SP1_OUT_TOL(sp1_out_tol), .SP2_OUT_TOL(sp2_out_tol), .WEIGHT_ASCII(weight_ascii),
      .TARE_ASCII(tare_ascii), .CHAR_READY(char_ready), .CHAR_DATA(char_data),
      .CHAR_VALID(char_valid), .FRAME_BUSY(frame_busy));

   wsbe_host_model i_wsbe_host_model (.clk(clk_sys), .rst(rst), .stall_en(stall_en),
      .char_data(char_data), .char_valid(char_valid), .char_ready(char_ready), .got(got),
      .got_data(got_data));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   task automatic note(input logic [7:0] ch);
      exp_q.push_back(ch);
      sum_acc = sum_acc + ch[6:0];
   endtask : note

   task automatic shake_flags();
      {build_code, net, negative, out_of_range, motion, kg_sel, power_up, print_req, expand,
         hand_tare, metric, sp_feed, sp_fast, sp1_out_tol, sp2_out_tol} = 20'(rnd());
      weight_ascii = 48'({rnd(), rnd()});
      tare_ascii = 48'({rnd(), rnd()});
   endtask : shake_flags

   // Expectations are noted before the request so that later input changes cannot leak in.
   task automatic run_frame(input logic [4:0] i);
      int n;
      @(negedge clk_sys);
      {stall_en, check_en, long_format, two_speed, setpoint_mode} = i;
      dp_code = i[2:0];
      unit_code = ~i[3:1];
      shake_flags();
      sum_acc = 7'h0;
      note(8'h02);
      note({1'b0, setpoint_mode & (two_speed ? ~sp_fast[0] : ~sp_feed[2]), 1'b1,
         setpoint_mode ? ~sp_feed[1:0] : build_code, dp_code});
      note({1'b0, setpoint_mode ? sp1_out_tol : power_up, 1'b1, kg_sel, motion,
         out_of_range, negative, net});
      note({1'b0, setpoint_mode ? sp2_out_tol : hand_tare & metric, 1'b1,
         setpoint_mode ? (two_speed ? ~sp_fast[1] : ~sp_feed[3]) : expand, print_req,
         unit_code});
      for (n = 5; n >= 0; n--) note(weight_ascii[n*8 +: 8]);
      if (long_format) for (n = 5; n >= 0; n--) note(tare_ascii[n*8 +: 8]);
      note(8'h0d);
      if (check_en) exp_q.push_back({1'b0, 7'h0 - sum_acc});
      frame_req = 1'b1;
      @(negedge clk_sys);
      frame_req = 1'b0;
      check({7'h0, frame_busy}, 8'h01);
      {check_en, long_format, setpoint_mode, two_speed} = ~{check_en, long_format,
         setpoint_mode, two_speed};
      shake_flags();
      // A request inside a running frame must be ignored; any extra character shows up
      // as an unexpected one in the watcher.
      frame_req = 1'b1;
      @(negedge clk_sys);
      frame_req = 1'b0;
      for (n = 0; n < 400 && frame_busy !== 1'b0; n++) @(negedge clk_sys);
      if (frame_busy !== 1'b0) begin
         mismatches++;
         report_and_stop();
      end
   endtask : run_frame

   always @(posedge clk_sys) begin
      if (got === 1'b1) begin
         if (exp_q.size() == 0) check(got_data, 8'hxx);
         else check(got_data, exp_q.pop_front());
      end
   end

   initial begin
      repeat (8) @(negedge clk_sys);
      check({7'h0, char_valid}, 8'h00);
      rst = 1'b0;
      for (int i = 0; i < 32; i++) run_frame(5'(i));
      repeat (4) @(negedge clk_sys);
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
endmodule : wsbe_encoder_tb
